// File: hw/usb_cmd_top.sv
// Request interpreter: packet in, bus transaction, response packet out
// Contract
// - Byte 0 ORs read 0x00 or write 0x10 with interface 0x08, 0x04, 0x02, 0x01 or 0x00.
// - Byte 1 is I2C target or SPI address high, byte 2 length, byte 3 register or address low.
// - A clean completion returns byte 0 as received with 0x20 added.
// - A failed bus transaction such as a missing I2C acknowledge returns byte 0 with 0x40 added.
// - An undefined byte 0 value returns that value with 0x80 added.
// - Bytes 1 and 3 echo the address for I2C; SPI returns data shifted in at byte 3, and at byte 1 for interface 0x04 only.
// - Byte 2 repeats the length and bytes 4 onward echo the request data.
// - A read fetches the given length from the given register and returns it from byte 4.
// - Interface 0x08 selects the seven-line port, the address bytes taking no part.
// - Port bit 7 is unused, bits 6..4 the upper lines and 3..0 the lower lines, high to low.
// - Port requests carry length one and bytes 1 and 3 are ignored.
// - A port read samples the lines into byte 4 and sets the completion flag.
module usb_cmd_top
  import usb_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_resetn,
  input  wire logic       i_req_valid,
  input  wire logic [7:0] i_req_data,
  input  wire logic       i_req_last,
  output logic            o_req_ready,
  output logic            o_rsp_valid,
  output logic [7:0]      o_rsp_data,
  output logic            o_rsp_last,
  input  wire logic       i_rsp_ready,
  input  wire logic       i_scl,
  output logic            o_scl,
  output logic            o_scl_oe,
  input  wire logic       i_sda,
  output logic            o_sda,
  output logic            o_sda_oe,
  output logic            o_spi_csn,
  output logic            o_spi_sclk,
  output logic            o_spi_mosi,
  input  wire logic       i_spi_miso,
  input  wire logic [6:0] i_port_lines,
  output logic            o_upper_port_line_c,
  output logic            o_upper_port_line_b,
  output logic            o_upper_port_line_a,
  output logic            o_lower_port_line_d,
  output logic            o_lower_port_line_c,
  output logic            o_lower_port_line_b,
  output logic            o_lower_port_line_a
);
  typedef enum logic [3:0] {
    ST_RX = 4'b0001, ST_RUN = 4'b0010, ST_WAIT = 4'b0100, ST_TX = 4'b1000
  } usb_state_type;
  typedef enum logic [7:0] {
    PH_START = 8'h01, PH_ADDR = 8'h02, PH_REGHI = 8'h04, PH_REG = 8'h08,
    PH_RSTART = 8'h10, PH_RADDR = 8'h20, PH_DATA = 8'h40, PH_STOP = 8'h80
  } usb_phase_type;

  logic [7:0]     buf_q [0:63];
  usb_state_type  st_q, st_d;
  usb_phase_type  ph_q, ph_d;
  logic [5:0]     idx_q, idx_d;
  logic [6:0]     cnt_q, cnt_d, rx_len_q, rx_len_d, rsp_len_q, rsp_len_d;
  logic [7:0]     stat_q, stat_d;
  logic           fail_q, fail_d, csn_q, csn_d;
  logic [6:0]     gpio_q, gpio_d, gp1_q, gp2_q;
  logic           mem_we, go, nlast, fin, eng_busy, eng_done, eng_nack;
  logic [5:0]     mem_addr, dp;
  logic [7:0]     mem_wd, obyte, eng_byte, b0, len_cap;
  usb_bus_op_type op;
  logic           wr, spi, gpio, code_ok, i2c_wr_ph;
  logic [9:0]     qtr;

  // Defined operation and interface combinations
  function automatic logic valid_code(input logic [7:0] b);
    logic [3:0] k;
    k = b[3:0];
    return (b[7:5] == 3'h0) && (k == IF_GPIO[3:0] || k == IF_SPI_WIDE[3:0] ||
           k == IF_I2C_FAST[3:0] || k == I2C_100K_SELECT[3:0] ||
           k == IF_SPI_NARROW[3:0]);
  endfunction

  // Request decode
  // operation and interface split
  assign b0      = buf_q[0];
  assign code_ok = valid_code(b0);
  assign wr      = b0[4];
  assign gpio    = (b0[3:0] == IF_GPIO[3:0]);
  assign spi     = (b0[3:0] == IF_SPI_WIDE[3:0]) || (b0[3:0] == IF_SPI_NARROW[3:0]);
  assign len_cap = (buf_q[POS_LEN] > DATA_MAX) ? DATA_MAX : buf_q[POS_LEN];
  assign dp      = idx_q + POS_DATA;
  assign qtr     = spi ? SPI_QTR : (b0[3:0] == IF_I2C_FAST[3:0]) ? FAST_QTR : STD_QTR;
  assign i2c_wr_ph = !spi && (ph_q == PH_ADDR || ph_q == PH_REG ||
                     ph_q == PH_RADDR || (ph_q == PH_DATA && wr));

  // Port input synchroniser
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      gp1_q <= 7'h00;
      gp2_q <= 7'h00;
    end else begin
      gp1_q <= i_port_lines;
      gp2_q <= gp1_q;
    end
  end

  // Sequencer next state
  always_comb begin
    st_d = st_q; ph_d = ph_q; idx_d = idx_q; cnt_d = cnt_q;
    rx_len_d = rx_len_q; rsp_len_d = rsp_len_q; stat_d = stat_q;
    fail_d = fail_q; csn_d = csn_q; gpio_d = gpio_q;
    mem_we = 1'b0; mem_addr = cnt_q[5:0]; mem_wd = i_req_data;
    go = 1'b0; op = BOP_START; obyte = 8'h00; nlast = 1'b0; fin = 1'b0;
    unique case (st_q)
      ST_RX: if (i_req_valid) begin
        mem_we = ~cnt_q[6];
        cnt_d  = (cnt_q == PKT_MAX) ? cnt_q : cnt_q + 7'h01;
        if (i_req_last) begin
          rx_len_d = cnt_d; cnt_d = 7'h00; idx_d = 6'h00; fail_d = 1'b0;
          st_d = ST_RUN; ph_d = PH_START;
        end
      end
      ST_RUN: begin
        go = (ph_q != PH_START); st_d = go ? ST_WAIT : st_q;
        unique case (ph_q)
          PH_START: if (!code_ok) begin
            stat_d = b0 | FLAG_REQ_ERROR; rsp_len_d = rx_len_q; st_d = ST_TX;
          end else if (gpio) begin
            if (wr) gpio_d = buf_q[POS_DATA][6:0];
            else begin
              // port lines sampled into byte 4
              mem_we = 1'b1; mem_addr = POS_DATA; mem_wd = {1'b0, gp2_q};
            end
            stat_d = b0 | FLAG_DONE; st_d = ST_TX;
            rsp_len_d = wr ? rx_len_q : GPIO_RSP_LEN;
          end else if (spi) begin
            csn_d = 1'b0; ph_d = b0[2] ? PH_REGHI : PH_REG;
          end else begin
            // I2C start runs in its own phase
            go = 1'b1; st_d = ST_WAIT;
          end
          PH_ADDR:   begin op = BOP_WRITE; obyte = {buf_q[POS_ADDR_HI][7:1], 1'b0}; end
          PH_REGHI:  begin op = BOP_XFER; obyte = buf_q[POS_ADDR_HI]; end
          PH_REG:    begin op = spi ? BOP_XFER : BOP_WRITE; obyte = buf_q[POS_REG]; end
          PH_RSTART: op = BOP_START;
          PH_RADDR:  begin op = BOP_WRITE; obyte = {buf_q[POS_ADDR_HI][7:1], 1'b1}; end
          PH_DATA: begin
            op    = spi ? BOP_XFER : (wr ? BOP_WRITE : BOP_READ);
            obyte = wr ? buf_q[dp] : 8'h00;
            nlast = ({2'b00, idx_q} == len_cap - 8'h01);
          end
          PH_STOP:   op = BOP_STOP;
        endcase
      end
      ST_WAIT: if (eng_done) begin
        st_d = ST_RUN;
        if (i2c_wr_ph && eng_nack) begin
          fail_d = 1'b1; ph_d = PH_STOP;
        end else begin
          unique case (ph_q)
            PH_START:  ph_d = PH_ADDR;
            PH_ADDR:   ph_d = PH_REG;
            PH_REGHI: begin
              mem_we = 1'b1; mem_addr = POS_ADDR_HI; mem_wd = eng_byte; ph_d = PH_REG;
            end
            PH_REG: begin
              mem_we = spi; mem_addr = POS_REG; mem_wd = eng_byte;
              if (len_cap == 8'h00) begin
                fin = spi; ph_d = PH_STOP;
              end else ph_d = (!spi && !wr) ? PH_RSTART : PH_DATA;
            end
            PH_RSTART: ph_d = PH_RADDR;
            PH_RADDR:  ph_d = PH_DATA;
            PH_DATA: begin
              mem_we = !wr; mem_addr = dp; mem_wd = eng_byte; idx_d = idx_q + 6'h01;
              if ({2'b00, idx_q} == len_cap - 8'h01) begin
                fin = spi; ph_d = PH_STOP;
              end
            end
            PH_STOP: fin = 1'b1;
          endcase
        end
      end
      ST_TX: if (i_rsp_ready) begin
        cnt_d = o_rsp_last ? 7'h00 : cnt_q + 7'h01;
        st_d  = o_rsp_last ? ST_RX : ST_TX;
      end
    endcase
    // response released only once the bus is idle
    if (fin) begin
      stat_d    = b0 | (fail_q ? BUS_FAILURE_FLAG : FLAG_DONE);
      csn_d     = 1'b1; st_d = ST_TX;
      rsp_len_d = wr ? rx_len_q : len_cap[6:0] + {1'b0, POS_DATA};
    end
  end

  // Sequencer registers
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_q <= ST_RX; ph_q <= PH_START; idx_q <= 6'h00; cnt_q <= 7'h00;
      rx_len_q <= 7'h00; rsp_len_q <= 7'h00; stat_q <= 8'h00;
      fail_q <= 1'b0; csn_q <= 1'b1; gpio_q <= GPIO_RESET;
    end else begin
      st_q <= st_d; ph_q <= ph_d; idx_q <= idx_d; cnt_q <= cnt_d;
      rx_len_q <= rx_len_d; rsp_len_q <= rsp_len_d; stat_q <= stat_d;
      fail_q <= fail_d; csn_q <= csn_d; gpio_q <= gpio_d;
    end
  end

  // Packet store
  always_ff @(posedge i_clk) begin
    if (mem_we) buf_q[mem_addr] <= mem_wd;
  end

  usb_bit_engine u_eng (
    .i_clk       (i_clk),
    .i_resetn    (i_resetn),
    .i_go        (go),
    .i_op        (op),
    .i_qtr       (qtr),
    .i_byte      (obyte),
    .i_nack_last (nlast),
    .i_scl       (i_scl),
    .i_sda       (i_sda),
    .i_miso      (i_spi_miso),
    .o_busy      (eng_busy),
    .o_done      (eng_done),
    .o_byte      (eng_byte),
    .o_nack      (eng_nack),
    .o_scl_oe    (o_scl_oe),
    .o_sda_oe    (o_sda_oe),
    .o_sclk      (o_spi_sclk),
    .o_mosi      (o_spi_mosi)
  );

  // Outputs
  // byte 0 from status, rest from the packet store
  assign o_req_ready = (st_q == ST_RX);
  assign o_rsp_valid = (st_q == ST_TX);
  assign o_rsp_data  = (cnt_q == 7'h00) ? stat_q : buf_q[cnt_q[5:0]];
  assign o_rsp_last  = (cnt_q == rsp_len_q - 7'h01);
  assign o_scl       = 1'b0;
  assign o_sda       = 1'b0;
  assign o_spi_csn   = csn_q;
  assign {o_upper_port_line_c, o_upper_port_line_b, o_upper_port_line_a} = gpio_q[6:4];
  assign {o_lower_port_line_d, o_lower_port_line_c, o_lower_port_line_b,
          o_lower_port_line_a} = gpio_q[3:0];

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  sequence s_rsp_open;
    $rose(o_rsp_valid);
  endsequence
  sequence s_port_read;
    st_q == ST_RUN && ph_q == PH_START && code_ok && gpio && !wr;
  endsequence

  chk_rsp_idle: assert property (o_rsp_valid |-> !eng_busy && o_spi_csn)
    else $error("response while bus busy");
  chk_done_flag: assert property (s_rsp_open ##0 code_ok && !fail_q |->
    o_rsp_data == (b0 | FLAG_DONE))
    else $error("completion flag wrong");
  chk_fail_flag: assert property (s_rsp_open ##0 fail_q |->
    o_rsp_data == (b0 | BUS_FAILURE_FLAG))
    else $error("failure flag wrong");
  chk_req_error: assert property (s_rsp_open ##0 !code_ok |->
    o_rsp_data == (b0 | FLAG_REQ_ERROR) && rsp_len_q == rx_len_q)
    else $error("request error flag wrong");
  chk_len_echo: assert property (o_rsp_valid && cnt_q == 7'h01 && i_rsp_ready |=>
    o_rsp_data == buf_q[POS_LEN])
    else $error("length not echoed");
  chk_port_write: assert property (st_q == ST_RUN && ph_q == PH_START && code_ok &&
    gpio && wr |=> {o_upper_port_line_c, o_lower_port_line_a} ==
    {$past(buf_q[POS_DATA][6]), $past(buf_q[POS_DATA][0])})
    else $error("port write mapping wrong");
  chk_port_read: assert property (s_port_read |=> o_rsp_valid ##0
    o_rsp_data == (b0 | FLAG_DONE) ##0 buf_q[POS_DATA] == {1'b0, $past(gp2_q)})
    else $error("port read response wrong");
  chk_read_len: assert property (s_rsp_open ##0 code_ok && !wr && !gpio |->
    rsp_len_q == len_cap[6:0] + 7'h04)
    else $error("read response length wrong");
  chk_i2c_quiet: assert property (!spi && st_q == ST_WAIT |-> o_spi_csn)
    else $error("chip select during I2C");
endmodule

// File: hw/usb_pkg.sv
// Shared constants and types for the USB request interpreter
package usb_pkg;
  localparam int        CLK_PERIOD_NS   = 5;
  // Byte 0 operation and interface codes
  localparam logic [7:0] OP_WRITE        = 8'h10;
  localparam logic [7:0] IF_GPIO         = 8'h08;
  localparam logic [7:0] IF_SPI_WIDE     = 8'h04;
  localparam logic [7:0] IF_I2C_FAST     = 8'h02;
  localparam logic [7:0] I2C_100K_SELECT = 8'h01;
  localparam logic [7:0] IF_SPI_NARROW   = 8'h00;
  // Status flags added to byte 0
  localparam logic [7:0] FLAG_REQ_ERROR   = 8'h80;
  localparam logic [7:0] BUS_FAILURE_FLAG = 8'h40;
  localparam logic [7:0] FLAG_DONE        = 8'h20;
  // Packet byte positions and limits
  localparam logic [5:0] POS_ADDR_HI = 6'h01;
  localparam logic [5:0] POS_LEN     = 6'h02;
  localparam logic [5:0] POS_REG     = 6'h03;
  localparam logic [5:0] POS_DATA    = 6'h04;
  localparam logic [6:0] PKT_MAX     = 7'h40;
  localparam logic [7:0] DATA_MAX    = 8'h3C;
  localparam logic [6:0] GPIO_RSP_LEN = 7'h05;
  localparam logic [6:0] GPIO_RESET  = 7'h00;
  // Bit periods and quarter-bit cycle counts
  localparam int         STD_BIT_NS  = 10000;
  localparam int         FAST_BIT_NS = 2500;
  localparam int         SPI_BIT_NS  = 1000;
  localparam logic [9:0] STD_QTR  = 10'(STD_BIT_NS / (4 * CLK_PERIOD_NS));
  localparam logic [9:0] FAST_QTR = 10'(FAST_BIT_NS / (4 * CLK_PERIOD_NS));
  localparam logic [9:0] SPI_QTR  = 10'(SPI_BIT_NS / (4 * CLK_PERIOD_NS));
  // Serial bus primitives
  typedef enum logic [4:0] {
    BOP_START = 5'b00001,
    BOP_STOP  = 5'b00010,
    BOP_WRITE = 5'b00100,
    BOP_READ  = 5'b01000,
    BOP_XFER  = 5'b10000
  } usb_bus_op_type;
endpackage

// File: hw/usb_bit_engine.sv
// Bit engine for I2C primitives and SPI byte exchange
module usb_bit_engine
  import usb_pkg::*;
(
  input  wire logic           i_clk,
  input  wire logic           i_resetn,
  input  wire logic           i_go,
  input  wire usb_bus_op_type i_op,
  input  wire logic [9:0]     i_qtr,
  input  wire logic [7:0]     i_byte,
  input  wire logic           i_nack_last,
  input  wire logic           i_scl,
  input  wire logic           i_sda,
  input  wire logic           i_miso,
  output logic                o_busy,
  output logic                o_done,
  output logic [7:0]          o_byte,
  output logic                o_nack,
  output logic                o_scl_oe,
  output logic                o_sda_oe,
  output logic                o_sclk,
  output logic                o_mosi
);
  logic [2:0]     s1_q, s2_q;
  logic           run_q, run_d, done_q, done_d, nack_q, nack_d, nl_q, nl_d;
  usb_bus_op_type op_q, op_d;
  logic [3:0]     bit_q, bit_d;
  logic [1:0]     qtr_q, qtr_d;
  logic [9:0]     cnt_q, cnt_d;
  logic [7:0]     sh_q, sh_d, rx_q, rx_d;
  logic           scl_oe_d, sda_oe_d, sclk_d, mosi_d;
  logic           scl_oe_q, sda_oe_q, sclk_q, mosi_q, sda_lag_q;
  logic [3:0]     last_bit;
  logic           hi, scl_rel, sda_rel, in_bit;

  // Two-flop synchronisers for scl, sda, miso
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s1_q <= 3'h7;
      s2_q <= 3'h7;
    end else begin
      s1_q <= {i_scl, i_sda, i_miso};
      s2_q <= s1_q;
    end
  end

  // Pin levels and sequencing per quarter bit
  always_comb begin
    hi       = qtr_q[1];
    last_bit = (op_q == BOP_XFER) ? 4'h7 :
               (op_q == BOP_START || op_q == BOP_STOP) ? 4'h0 : 4'h8;
    scl_rel  = hi;
    sda_rel  = 1'b1;
    unique case (op_q)
      BOP_START: begin
        // Clock low first so a repeated start sees data rise
        sda_rel = ~hi;
        scl_rel = (qtr_q == 2'h1) || (qtr_q == 2'h2);
      end
      BOP_STOP: begin
        sda_rel = hi;
        scl_rel = (qtr_q != 2'h0);
      end
      BOP_WRITE: sda_rel = (bit_q == 4'h8) | sh_q[7];
      BOP_READ:  sda_rel = (bit_q != 4'h8) | nl_q;
      BOP_XFER:  sda_rel = 1'b1;
    endcase
    in_bit   = (op_q == BOP_XFER) ? s2_q[0] : s2_q[1];
    run_d = run_q; op_d = op_q; bit_d = bit_q; qtr_d = qtr_q; cnt_d = cnt_q;
    sh_d = sh_q; rx_d = rx_q; nack_d = nack_q; nl_d = nl_q; done_d = 1'b0;
    if (!run_q) begin
      if (i_go) begin
        run_d = 1'b1; op_d = i_op; sh_d = i_byte; nl_d = i_nack_last;
        bit_d = 4'h0; qtr_d = 2'h0; cnt_d = i_qtr - 10'h001; nack_d = 1'b0;
      end
    end else if (op_q != BOP_XFER && scl_rel && !s2_q[2]) begin
      cnt_d = cnt_q;
    end else if (cnt_q != 10'h000) begin
      cnt_d = cnt_q - 10'h001;
    end else begin
      cnt_d = i_qtr - 10'h001;
      qtr_d = qtr_q + 2'h1;
      if (qtr_q == 2'h3) begin
        if (bit_q == 4'h8 && op_q == BOP_WRITE) nack_d = in_bit;
        else if (bit_q != 4'h8) rx_d = {rx_q[6:0], in_bit};
        if (bit_q == last_bit) begin
          run_d  = 1'b0;
          done_d = 1'b1;
        end else begin
          bit_d = bit_q + 4'h1;
          sh_d  = {sh_q[6:0], 1'b0};
        end
      end
    end
    // I2C lines hold their level between primitives, no glitch; SPI clock and data drop low
    scl_oe_d = run_q ? (~scl_rel & (op_q != BOP_XFER)) : scl_oe_q;
    sda_oe_d = run_q ? (~sda_rel & (op_q != BOP_XFER)) : sda_oe_q;
    sclk_d   = run_q & hi & (op_q == BOP_XFER);
    mosi_d   = run_q & sh_q[7] & (op_q == BOP_XFER);
  end

  // Engine state and registered pins
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      run_q <= 1'b0; op_q <= BOP_START; bit_q <= 4'h0; qtr_q <= 2'h0;
      cnt_q <= 10'h000; sh_q <= 8'h00; rx_q <= 8'h00; nack_q <= 1'b0;
      nl_q <= 1'b0; done_q <= 1'b0; scl_oe_q <= 1'b0; sda_oe_q <= 1'b0;
      sclk_q <= 1'b0; mosi_q <= 1'b0; sda_lag_q <= 1'b0;
    end else begin
      run_q <= run_d; op_q <= op_d; bit_q <= bit_d; qtr_q <= qtr_d;
      cnt_q <= cnt_d; sh_q <= sh_d; rx_q <= rx_d; nack_q <= nack_d;
      nl_q <= nl_d; done_q <= done_d; scl_oe_q <= scl_oe_d;
      sda_oe_q <= sda_oe_d; sclk_q <= sclk_d; mosi_q <= mosi_d;
      sda_lag_q <= sda_oe_q;
    end
  end

  assign o_busy   = run_q | done_q;
  assign o_done   = done_q;
  assign o_byte   = rx_q;
  assign o_nack   = nack_q;
  assign o_scl_oe = scl_oe_q;
  assign o_sda_oe = sda_lag_q; // Data lags clock one cycle for hold
  assign o_sclk   = sclk_q;
  assign o_mosi   = mosi_q;
endmodule

// File: tb/usb_far_model.sv
// Behavioural I2C target and SPI peripheral on the far side of the bus pins
module usb_far_model #(
  parameter logic [6:0] I2C_ADDR = 7'h50,
  parameter logic [7:0] SPI_PAT  = 8'h96
) (
  input  wire logic i_scl,
  input  wire logic i_sda,
  output logic      o_sda_pull,
  input  wire logic i_spi_csn,
  input  wire logic i_spi_sclk,
  input  wire logic i_spi_mosi,
  output logic      o_spi_miso
);
  timeunit 1ns;
  timeprecision 100ps;
  int unsigned bit_n = 0;
  int unsigned idx = 0;
  logic        active = 1'b0;
  logic        rd = 1'b0;
  logic [7:0]  sh = 8'h00;
  logic [7:0]  rd_byte;
  logic [2:0]  sbit = 3'h0;
  logic [7:0]  mosi_sh = 8'h00;
  logic [7:0]  spi_got[$];
  initial o_sda_pull = 1'b0;
  initial o_spi_miso = 1'b0;
  // Read data served by the target
  assign rd_byte = 8'hC0 | 8'(idx);
  // Start or repeated start restarts byte framing
  always @(negedge i_sda) if (i_scl === 1'b1) begin
    bit_n = 0;
    idx = 0;
    active = 1'b0;
    rd = 1'b0;
  end
  // Bits are taken while the clock is high
  always @(posedge i_scl) if (bit_n < 8) begin
    sh = {sh[6:0], i_sda};
    bit_n++;
  end
  // Acknowledge and read data change only while the clock is low
  always @(negedge i_scl) begin
    if (bit_n == 8) begin
      if (idx == 0) begin
        active = (sh[7:1] == I2C_ADDR);
        rd = sh[0];
      end
      o_sda_pull = active && (idx == 0 || !rd);
      bit_n = 9;
    end else if (bit_n == 9) begin
      bit_n = 0;
      idx++;
      o_sda_pull = 1'b0;
    end
    if (active && rd && idx != 0 && bit_n < 8) o_sda_pull = !rd_byte[7 - bit_n];
  end
  // SPI mode 0: first bit presented on select
  always @(negedge i_spi_csn) begin
    sbit = 3'h0;
    o_spi_miso = SPI_PAT[7];
  end
  always @(posedge i_spi_sclk) if (!i_spi_csn) begin
    mosi_sh = {mosi_sh[6:0], i_spi_mosi};
    sbit++;
    if (sbit == 3'h0) spi_got.push_back(mosi_sh);
  end
  always @(negedge i_spi_sclk) if (!i_spi_csn) o_spi_miso = SPI_PAT[7 - sbit];
  // Deselected output shows no stale level
  always @(posedge i_spi_csn) o_spi_miso = ~o_spi_miso;
endmodule

// File: tb/testbench.sv
// Self-checking bench for the request interpreter
module testbench
  import usb_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef logic [7:0] usb_tb_bytes_type[$];
  logic       i_clk = 1'b0;
  logic       i_resetn = 1'b0;
  logic       req_valid = 1'b0;
  logic [7:0] req_data = 8'h00;
  logic       req_last = 1'b0;
  logic       rsp_ready = 1'b0;
  logic [6:0] port_in = 7'h2A;
  logic [7:0] rsp_data;
  logic [6:0] port_out;
  logic       req_ready;
  logic       rsp_valid;
  logic       rsp_last;
  logic       scl_oe;
  logic       sda_oe;
  logic       sda_pull;
  logic       spi_csn;
  logic       spi_sclk;
  logic       spi_mosi;
  logic       spi_miso;
  logic       scl_w;
  logic       sda_w;
  logic       scl_lvl;
  logic       sda_lvl;
  int         num_errors = 0;
  int         checks_done = 0;
  int         cycles = 0;
  logic [7:0] bad[4] = '{8'h13, 8'h0C, 8'h1F, 8'h30};
  always #2.5 i_clk = ~i_clk;
  // Open-drain lines with pull-up
  assign scl_w = !scl_oe;
  assign sda_w = !(sda_oe || sda_pull);
  usb_cmd_top u_dut (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_req_valid(req_valid), .i_req_data(req_data),
    .i_req_last(req_last), .o_req_ready(req_ready), .o_rsp_valid(rsp_valid),
    .o_rsp_data(rsp_data), .o_rsp_last(rsp_last), .i_rsp_ready(rsp_ready),
    .i_scl(scl_w), .o_scl(scl_lvl), .o_scl_oe(scl_oe), .i_sda(sda_w), .o_sda(sda_lvl),
    .o_sda_oe(sda_oe), .o_spi_csn(spi_csn), .o_spi_sclk(spi_sclk),
    .o_spi_mosi(spi_mosi), .i_spi_miso(spi_miso), .i_port_lines(port_in),
    .o_upper_port_line_c(port_out[6]), .o_upper_port_line_b(port_out[5]),
    .o_upper_port_line_a(port_out[4]), .o_lower_port_line_d(port_out[3]),
    .o_lower_port_line_c(port_out[2]), .o_lower_port_line_b(port_out[1]),
    .o_lower_port_line_a(port_out[0])
  );
  usb_far_model u_far (
    .i_scl(scl_w), .i_sda(sda_w), .o_sda_pull(sda_pull), .i_spi_csn(spi_csn),
    .i_spi_sclk(spi_sclk), .i_spi_mosi(spi_mosi), .o_spi_miso(spi_miso)
  );
  // Verdict and end of run
  task automatic stop_test();
    $display("TB: errors=%0d checks=%0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Hang guard
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 100000) begin
      num_errors++;
      stop_test();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Response that repeats the request with flags added to byte 0
  function automatic usb_tb_bytes_type echo(input usb_tb_bytes_type q, input logic [7:0] f);
    usb_tb_bytes_type r;
    r = q;
    r[0] = q[0] | f;
    return r;
  endfunction
  task automatic run(input usb_tb_bytes_type req, input usb_tb_bytes_type exp);
    int n;
    n = 0;
    foreach (req[i]) begin
      req_valid <= 1'b1;
      req_data <= req[i];
      req_last <= (i == req.size() - 1);
      @(posedge i_clk);
    end
    req_valid <= 1'b0;
    req_last <= 1'b0;
    rsp_ready <= 1'b1;
    while (n < exp.size()) begin
      @(negedge i_clk);
      if (rsp_valid === 1'b1) begin
        if (n == 0) chk({3'h0, scl_lvl, sda_lvl, spi_csn, scl_oe, sda_oe}, 8'h04);
        if (n == 0) chk({7'h00, req_ready}, 8'h00);
        chk(rsp_data, exp[n]);
        chk({7'h00, rsp_last}, {7'h00, n == exp.size() - 1});
        n++;
      end
    end
    @(posedge i_clk);
    rsp_ready <= 1'b0;
    @(negedge i_clk);
    chk({6'h00, req_ready, rsp_valid}, 8'h02);
    @(posedge i_clk);
  endtask
  // Bytes the SPI peripheral saw on its data input
  task automatic wire_chk(input usb_tb_bytes_type e);
    chk(8'(u_far.spi_got.size()), 8'(e.size()));
    foreach (e[i]) chk(u_far.spi_got[i], e[i]);
    u_far.spi_got.delete();
  endtask
  // Main sequence
  initial begin
    usb_tb_bytes_type req;
    usb_tb_bytes_type exp;
    repeat (12) @(posedge i_clk);
    i_resetn <= 1'b1;
    @(posedge i_clk);
    req = '{8'h18, 8'h7E, 8'h01, 8'h33, 8'hD5};
    run(req, echo(req, FLAG_DONE));
    chk({1'b0, port_out}, 8'h55);
    req = '{8'h08, 8'h11, 8'h01, 8'h22};
    exp = echo(req, FLAG_DONE);
    exp.push_back(8'h2A);
    run(req, exp);
    foreach (bad[i]) begin
      req = '{bad[i], 8'hA0, 8'h02, 8'h05, 8'hAA, 8'h55};
      run(req, echo(req, FLAG_REQ_ERROR));
    end
    req = '{8'h12, 8'hA0, 8'h01, 8'h05, 8'hAA};
    run(req, echo(req, FLAG_DONE));
    req = '{8'h02, 8'hA0, 8'h02, 8'h05};
    exp = echo(req, FLAG_DONE);
    exp.push_back(8'hC1);
    exp.push_back(8'hC2);
    run(req, exp);
    req = '{8'h11, 8'hB0, 8'h01, 8'h05, 8'hAA};
    run(req, echo(req, BUS_FAILURE_FLAG));
    req = '{8'h10, 8'hA0, 8'h02, 8'h05, 8'hAA, 8'h55};
    exp = echo(req, FLAG_DONE);
    exp[3] = 8'h96;
    run(req, exp);
    wire_chk('{8'h05, 8'hAA, 8'h55});
    req = '{8'h04, 8'h10, 8'h02, 8'hE0};
    exp = echo(req, FLAG_DONE);
    exp[1] = 8'h96;
    exp[3] = 8'h96;
    exp.push_back(8'h96);
    exp.push_back(8'h96);
    run(req, exp);
    wire_chk('{8'h10, 8'hE0, 8'h00, 8'h00});
    stop_test();
  end
endmodule
